// File: rtl/rbs_pkg.sv
// rbs_pkg: opcode patterns, field positions and carrier types for the
// rotate / bit-skip / set-bit / power-down execution group.
// assumes 12-bit instruction words and an 8-bit data path.
package rbs_pkg;
  localparam int OP_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  // opcode patterns
  localparam logic [6:0] ROTATE_LEFT_PAT = 7'h1b;   // 0011 011
  localparam logic [6:0] ROTATE_RIGHT_PAT = 7'h19;  // 0011 001
  localparam logic [3:0] SKIP_SET_PAT = 4'h7;       // 0111
  localparam logic [3:0] SET_BIT_PAT = 4'h5;        // 0101
  localparam logic [11:0] POWER_DOWN_PAT = 12'h003;
  // field positions
  localparam int BIT_LSB = 5;
  localparam int ADDR_LSB = 0;
  // values after reset / on power-down entry
  localparam logic [7:0] WDOG_CLEAR_VAL = 8'h00;
  localparam logic EXPIRY_ON_SLEEP = 1'b1;
  localparam logic PDOWN_ON_SLEEP = 1'b0;
  localparam logic EXPIRY_RST = 1'b1;
  localparam logic PDOWN_RST = 1'b1;

  typedef enum logic [2:0] {
    RBS_OP_NONE = 3'b000,
    RBS_OP_RL = 3'b001,
    RBS_OP_RR = 3'b010,
    RBS_OP_SKIP = 3'b011,
    RBS_OP_SET = 3'b100,
    RBS_OP_SLEEP = 3'b101
  } rbs_op_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } rbs_wr_t;

  typedef struct packed {
    logic we;
    logic value;
  } rbs_flag_wr_t;
endpackage

// File: rtl/rbs_exec.sv
// rbs_exec: executes rotate-through-carry, skip-if-bit-set, set-bit and
// power-down instructions handed over by the fetch/decode stage.
// assumes the register file answers reg_rdata for instr_addr in the
// same cycle (combinational read) and commits writes one edge later.
`timescale 1ns/1ps
// Operation
// RULE1: 0011011 in bits 11:5 decodes as rotate-left through carry.
// RULE2: rotate-left moves bits up, carry into bit 0, bit 7 to carry.
// RULE3: 0011001 in bits 11:5 decodes as rotate-right through carry.
// RULE4: rotate-right moves bits down, carry into bit 7, bit 0 to carry.
// RULE5: skip-if-set skips the next word when the tested bit is one.
// RULE6: skip-if-set takes one cycle, or two when the skip is taken.
// RULE7: 0101 in bits 11:8 sets the addressed bit, nothing else changes.
// RULE8: bit number is opcode bits 7:5, register address bits 4:0.
// RULE9: only 000000000011 is power-down, one cycle, ALU flags untouched.
// RULE10: power-down with watchdog on clears count, expiry 1, pd flag 0.
// RULE11: power-down ends only on overflow, wake-pin edge or reset pin.
// RULE12: a skipped word is annulled and its slot spent as a no-op.
module rbs_exec (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // instruction from fetch/decode
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  // register file and flags
  input wire logic [7:0] reg_rdata,
  input wire logic carry_in,
  // watchdog and wake-up sources
  input wire logic wdog_enable,
  input wire logic wdog_overflow,
  input wire logic wake_pin,
  input wire logic external_reset_pin,
  // register and flag writes
  output rbs_pkg::rbs_wr_t reg_wr,
  output rbs_pkg::rbs_flag_wr_t carry_wr,
  // watchdog count control
  output logic wdog_clear,
  // status and core control
  output logic watchdog_expiry_flag,
  output logic power_down_flag,
  output logic annul,
  output logic osc_stop,
  output logic instr_done
);
  function automatic rbs_pkg::rbs_op_t decode(input logic [11:0] w);
    if (w[11:5] == rbs_pkg::ROTATE_LEFT_PAT)
      return rbs_pkg::RBS_OP_RL; // RULE1
    else if (w[11:5] == rbs_pkg::ROTATE_RIGHT_PAT)
      return rbs_pkg::RBS_OP_RR; // RULE3
    else if (w[11:8] == rbs_pkg::SKIP_SET_PAT)
      return rbs_pkg::RBS_OP_SKIP;
    else if (w[11:8] == rbs_pkg::SET_BIT_PAT)
      return rbs_pkg::RBS_OP_SET; // RULE7
    else if (w == rbs_pkg::POWER_DOWN_PAT)
      return rbs_pkg::RBS_OP_SLEEP; // RULE9
    else
      return rbs_pkg::RBS_OP_NONE;
  endfunction

  rbs_pkg::rbs_op_t op;
  logic [2:0] bit_sel;
  logic [4:0] file_register_operand;
  logic tested_bit;
  logic skip_pending_r;
  logic sleeping_r;
  logic live;
  logic pin_d_r;
  logic wake_evt;
  logic slot_fill;
  logic do_rl;
  logic do_rr;
  logic do_set;
  logic do_skip_hit;
  logic do_skip_miss;
  logic do_sleep;

  assign op = decode(instr);
  assign bit_sel = instr[rbs_pkg::BIT_LSB +: 3]; // RULE8
  assign file_register_operand = instr[rbs_pkg::ADDR_LSB +: 5]; // RULE8
  assign tested_bit = reg_rdata[bit_sel];
  // no instruction executes while asleep or during the annulled slot
  assign live = instr_valid && !skip_pending_r && !sleeping_r;
  assign wake_evt = wdog_overflow || (wake_pin != pin_d_r)
    || external_reset_pin;
  assign slot_fill = skip_pending_r && instr_valid;

  // one strobe per action taken this cycle
  always_comb begin
    do_rl = 1'b0;
    do_rr = 1'b0;
    do_set = 1'b0;
    do_skip_hit = 1'b0;
    do_skip_miss = 1'b0;
    do_sleep = 1'b0;
    if (live) begin
      case (op)
        rbs_pkg::RBS_OP_RL: begin
          do_rl = 1'b1;
        end
        rbs_pkg::RBS_OP_RR: begin
          do_rr = 1'b1;
        end
        rbs_pkg::RBS_OP_SET: begin
          do_set = 1'b1;
        end
        rbs_pkg::RBS_OP_SKIP: begin
          do_skip_hit = tested_bit;
          do_skip_miss = !tested_bit;
        end
        rbs_pkg::RBS_OP_SLEEP: begin
          do_sleep = 1'b1;
        end
        default: begin
          do_rl = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= wake_pin;
    end
  end

  // register writes: rotates and set-bit, all single cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_wr <= '0;
    end else begin
      reg_wr.we <= 1'b0;
      reg_wr.addr <= file_register_operand;
      reg_wr.data <= reg_rdata;
      if (live) begin
        case (op)
          rbs_pkg::RBS_OP_RL: begin
            reg_wr.we <= 1'b1;
            reg_wr.data <= {reg_rdata[6:0], carry_in}; // RULE2
          end
          rbs_pkg::RBS_OP_RR: begin
            reg_wr.we <= 1'b1;
            reg_wr.data <= {carry_in, reg_rdata[7:1]}; // RULE4
          end
          rbs_pkg::RBS_OP_SET: begin
            reg_wr.we <= 1'b1;
            reg_wr.data <= reg_rdata | (8'h01 << bit_sel); // RULE7
          end
          default: begin
            reg_wr.we <= 1'b0;
          end
        endcase
      end
    end
  end

  // carry is the only ALU flag this group touches
  always_ff @(posedge core_clk) begin
    if (srst) begin
      carry_wr <= '0;
    end else begin
      carry_wr.we <= 1'b0;
      carry_wr.value <= 1'b0;
      if (do_rl) begin
        carry_wr.we <= 1'b1;
        carry_wr.value <= reg_rdata[7]; // RULE2
      end else if (do_rr) begin
        carry_wr.we <= 1'b1;
        carry_wr.value <= reg_rdata[0]; // RULE4
      end
    end
  end

  // skip: the next fetched word is annulled and costs one extra cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      skip_pending_r <= 1'b0;
      annul <= 1'b0;
    end else begin
      annul <= 1'b0;
      if (slot_fill) begin
        skip_pending_r <= 1'b0; // RULE12
        annul <= 1'b1; // RULE12
      end else if (do_skip_hit) begin
        skip_pending_r <= 1'b1; // RULE5
      end
    end
  end

  // done pulse per instruction; a taken skip ends on the annulled slot
  always_ff @(posedge core_clk) begin
    if (srst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (slot_fill)
        instr_done <= 1'b1; // RULE6
      else if (do_rl || do_rr || do_set || do_skip_miss || do_sleep)
        instr_done <= 1'b1; // RULE6
    end
  end

  // power-down entry and exit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sleeping_r <= 1'b0;
      osc_stop <= 1'b0;
      wdog_clear <= 1'b0;
      watchdog_expiry_flag <= rbs_pkg::EXPIRY_RST;
      power_down_flag <= rbs_pkg::PDOWN_RST;
    end else begin
      wdog_clear <= 1'b0;
      if (sleeping_r) begin
        if (wake_evt) begin
          sleeping_r <= 1'b0; // RULE11
          osc_stop <= 1'b0;
        end
      end else if (do_sleep) begin
        sleeping_r <= 1'b1; // RULE9
        osc_stop <= 1'b1;
        if (wdog_enable) begin
          wdog_clear <= 1'b1; // RULE10
          watchdog_expiry_flag <= rbs_pkg::EXPIRY_ON_SLEEP; // RULE10
          power_down_flag <= rbs_pkg::PDOWN_ON_SLEEP; // RULE10
        end
      end
    end
  end
endmodule // rbs_exec

// File: sim/rbs_exec_properties.sv
// rbs_exec_properties: port-level timing checks for rbs_exec.
// assumes bind to rbs_exec; helper regs hold last cycle's operands.
`timescale 1ns/1ps
module rbs_exec_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // stimulus side
  input wire logic instr_valid,
  input wire logic carry_in,
  input wire logic [11:0] instr,
  input wire logic [7:0] reg_rdata,
  input wire logic wdog_enable,
  input wire logic wdog_overflow,
  input wire logic wake_pin,
  input wire logic external_reset_pin,
  // design outputs
  input wire rbs_pkg::rbs_wr_t reg_wr,
  input wire rbs_pkg::rbs_flag_wr_t carry_wr,
  input wire logic wdog_clear,
  input wire logic watchdog_expiry_flag,
  input wire logic power_down_flag,
  input wire logic annul,
  input wire logic osc_stop,
  input wire logic instr_done
);
  logic [7:0] d_r, m_r;
  logic [4:0] a_r;
  logic c_r, slot_r, slp_r;
  wire tk = instr_valid && !osc_stop && !slot_r;
  wire tst = tk && instr[11:8] == 4'h7;
  wire hit = tst && reg_rdata[instr[7:5]];
  wire no_wr = !reg_wr.we && !carry_wr.we;
  always_ff @(posedge core_clk) begin
    d_r <= reg_rdata;
    c_r <= carry_in;
    a_r <= instr[4:0];
    m_r <= 8'h01 << instr[7:5];
  end
  // slot waits for the first valid word after a taken skip
  always_ff @(posedge core_clk) begin
    slot_r <= !srst && (slot_r ? !instr_valid : hit);
    slp_r <= !srst && tk && instr == 12'h003;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rot_left: assert property (
    tk && instr[11:5] == 7'h1b |=> instr_done &&
    reg_wr == {1'b1, a_r, d_r[6:0], c_r} && carry_wr == {1'b1, d_r[7]}
  ) else $error("rotate left wrong");
  a_rot_right: assert property (
    tk && instr[11:5] == 7'h19 |=> instr_done &&
    reg_wr == {1'b1, a_r, c_r, d_r[7:1]} && carry_wr == {1'b1, d_r[0]}
  ) else $error("rotate right wrong");
  a_set_bit: assert property (
    tk && instr[11:8] == 4'h5 |=> instr_done && !carry_wr.we &&
    reg_wr == {1'b1, a_r, d_r | m_r}
  ) else $error("set bit wrong");
  a_skip_clear: assert property (
    tst && !hit |=> instr_done && !annul && no_wr
  ) else $error("untaken skip wrong");
  a_skip_hold: assert property (
    hit |=> !instr_done && no_wr
  ) else $error("taken skip finished early");
  a_skip_annul: assert property (
    hit ##1 instr_valid |=> annul && instr_done && no_wr
  ) else $error("skipped word not annulled");
  a_sleep_in: assert property (
    tk && instr == 12'h003 && wdog_enable |=> osc_stop && wdog_clear &&
    watchdog_expiry_flag && !power_down_flag && !carry_wr.we
  ) else $error("power-down entry wrong");
  a_sleep_hold: assert property (
    osc_stop && !wdog_overflow && !external_reset_pin && $stable(wake_pin)
    |=> osc_stop
  ) else $error("left power-down without cause");
  a_wake_exit: assert property (
    osc_stop && (wdog_overflow || external_reset_pin) |=> !osc_stop
  ) else $error("wake event ignored");
  a_flags_quiet: assert property (
    !slp_r && !$past(srst) |-> $stable({watchdog_expiry_flag, power_down_flag})
  ) else $error("status flags changed");
  c_skip: cover property (hit ##1 instr_valid ##1 annul);
  c_sleep: cover property (slp_r && osc_stop);
  c_wake: cover property (osc_stop ##1 !osc_stop);
endmodule // rbs_exec_properties

// File: sim/tb.sv
// tb: random operand traffic and power-down/wake runs for rbs_exec.
// assumes registered outputs visible right after the taking edge.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, carry_in = 1'b0;
  logic wdog_enable = 1'b0, wdog_overflow = 1'b0, wake_pin = 1'b0;
  logic external_reset_pin = 1'b0, c;
  logic [11:0] instr = 12'h000;
  logic [7:0] reg_rdata = 8'h00, d;
  logic [4:0] a;
  logic [2:0] b;
  rbs_pkg::rbs_wr_t reg_wr;
  rbs_pkg::rbs_flag_wr_t carry_wr;
  logic wdog_clear, watchdog_expiry_flag, power_down_flag;
  logic annul, osc_stop, instr_done;
  logic [15:0] exp_q[$];
  logic [15:0] seen, want;
  int num_errors = 0, checks = 0;
  rbs_exec rbs_exec_i (
    .core_clk(core_clk),
    .srst(srst),
    .instr_valid(instr_valid),
    .instr(instr),
    .reg_rdata(reg_rdata),
    .carry_in(carry_in),
    .wdog_enable(wdog_enable),
    .wdog_overflow(wdog_overflow),
    .wake_pin(wake_pin),
    .external_reset_pin(external_reset_pin),
    .reg_wr(reg_wr),
    .carry_wr(carry_wr),
    .wdog_clear(wdog_clear),
    .watchdog_expiry_flag(watchdog_expiry_flag),
    .power_down_flag(power_down_flag),
    .annul(annul),
    .osc_stop(osc_stop),
    .instr_done(instr_done)
  );
  initial forever #2 core_clk = ~core_clk;
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_wr(logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD writes exp %h got %h", e, s);
    end
  endtask
  task automatic chk_st(logic [3:0] e);
    checks++;
    if ({osc_stop, wdog_clear, watchdog_expiry_flag, power_down_flag} !== e)
    begin
      num_errors++;
      $display("BAD status exp %h got %h", e,
        {osc_stop, wdog_clear, watchdog_expiry_flag, power_down_flag});
    end
  endtask
  task automatic chk_an(logic e);
    checks++;
    if (annul !== e) begin
      num_errors++;
      $display("BAD annul exp %b got %b", e, annul);
    end
  endtask
  task automatic op(logic [11:0] w, logic [7:0] v, logic cv,
    logic [15:0] e, bit p);
    instr_valid <= 1'b1;
    instr <= w;
    reg_rdata <= v;
    carry_in <= cv;
    if (p) exp_q.push_back(e);
    @(posedge core_clk);
    #1;
  endtask
  // masked so stale fields behind a low strobe do not count
  always @(posedge core_clk) begin
    #1;
    if (instr_done === 1'b1) begin
      want = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
      seen = {reg_wr.we ? reg_wr : 14'h0000, carry_wr.we ? carry_wr : 2'h0};
      chk_wr(want, seen);
    end
  end
  initial begin
    void'($urandom(1));
    repeat (2) @(posedge core_clk);
    #1;
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = 5'($urandom);
      d = 8'($urandom);
      c = 1'($urandom);
      b = i[2:0];
      op({7'h1b, a}, d, c, {1'b1, a, d[6:0], c, 1'b1, d[7]}, 1);
      op({7'h19, a}, d, c, {1'b1, a, c, d[7:1], 1'b1, d[0]}, 1);
      op({4'h5, b, a}, d, c, {1'b1, a, d | (8'h01 << b), 2'h0}, 1);
      op({4'h7, b, a}, d & ~(8'h01 << b), c, 16'h0000, 1);
      chk_an(1'b0);
      op({4'h7, b, a}, d | (8'h01 << b), c, 16'h0000, 0);
      chk_an(1'b0);
      op({7'h1b, a}, d, c, 16'h0000, 1);
      chk_an(1'b1);
      op(12'h013, d, c, 16'h0000, 0);
    end
    for (int k = 0; k < 3; k++) begin
      wdog_enable <= (k != 0);
      op(12'h003, d, c, 16'h0000, 1);
      instr <= {7'h1b, a};
      chk_st({1'b1, k != 0, 1'b1, k == 0});
      repeat (3) @(posedge core_clk);
      #1;
      chk_st({1'b1, 1'b0, 1'b1, k == 0});
      instr_valid <= 1'b0;
      wdog_overflow <= (k == 0);
      wake_pin <= wake_pin ^ (k == 1);
      external_reset_pin <= (k == 2);
      @(posedge core_clk);
      #1;
      chk_st({1'b0, 1'b0, 1'b1, k == 0});
      wdog_overflow <= 1'b0;
      external_reset_pin <= 1'b0;
    end
    if (exp_q.size() != 0) num_errors++;
    complete_run();
  end
  initial begin
    #4000;
    num_errors++;
    complete_run();
  end
endmodule // tb
bind rbs_exec rbs_exec_properties rbs_exec_properties_i (
  .core_clk(core_clk),
  .srst(srst),
  .instr_valid(instr_valid),
  .carry_in(carry_in),
  .instr(instr),
  .reg_rdata(reg_rdata),
  .wdog_enable(wdog_enable),
  .wdog_overflow(wdog_overflow),
  .wake_pin(wake_pin),
  .external_reset_pin(external_reset_pin),
  .reg_wr(reg_wr),
  .carry_wr(carry_wr),
  .wdog_clear(wdog_clear),
  .watchdog_expiry_flag(watchdog_expiry_flag),
  .power_down_flag(power_down_flag),
  .annul(annul),
  .osc_stop(osc_stop),
  .instr_done(instr_done)
);
